// *** logic/fdsg_pkg.sv ***
// package for the flash debug security gate: register map, field layout,
// reset values, power mode codes and timing constants.
// assumes a single 50 MHz system clock shared by every user of the package.
package fdsg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and throttling
   localparam int unsigned FDSG_CLK_HZ     = 50_000_000; // system clock rate
   localparam int unsigned FDSG_LP_ACC_HZ  = 1_000_000;  // flash rate cap, low power run
   // longest access spacing rounds down, never below one cycle
   localparam int unsigned FDSG_LP_DIV_RAW = FDSG_CLK_HZ / FDSG_LP_ACC_HZ;
   localparam int unsigned FDSG_LP_DIV     = (FDSG_LP_DIV_RAW < 1) ? 1 : FDSG_LP_DIV_RAW;
   localparam int unsigned FDSG_DIV_W      = $clog2(FDSG_LP_DIV + 1);

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses on the avalon slave)
   localparam logic [3:0] FDSG_STATUS_OFS  = 4'h0; // read only state
   localparam logic [3:0] FDSG_CONTROL_OFS = 4'h4; // debug control access port

   // status fields
   localparam int unsigned FDSG_ST_STATE_LSB  = 0; // security_state_field, 2 bits
   localparam int unsigned FDSG_ST_MEF_LSB    = 2; // mass_erase_enable_field, 2 bits
   localparam int unsigned FDSG_ST_SECURED    = 4;
   localparam int unsigned FDSG_ST_ME_OFF     = 5; // debugger mass erase disabled
   localparam int unsigned FDSG_ST_LOADED     = 6;
   localparam int unsigned FDSG_ST_ME_BUSY    = 7;

   // control fields
   localparam int unsigned FDSG_CT_ME_REQ     = 0; // mass erase request / in progress
   localparam int unsigned FDSG_CT_DBG_DIS    = 1; // debug disable

   // configuration byte layout
   localparam int unsigned FDSG_CFG_STATE_LSB = 0;
   localparam int unsigned FDSG_CFG_MEF_LSB   = 4;

   // encodings and reset values
   localparam logic [1:0] FDSG_STATE_UNSECURE = 2'h2; // only open encoding
   localparam logic [1:0] FDSG_MEF_DISABLED   = 2'h2; // erase blocked when secured
   localparam logic [1:0] FDSG_STATE_RST      = 2'h3; // secured until loaded
   localparam logic [1:0] FDSG_MEF_RST        = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // power mode input codes (driven by the mode controller)
   typedef enum logic [1:0] {
      FDSG_MODE_RUN     = 2'h0,
      FDSG_MODE_HSRUN   = 2'h1,
      FDSG_MODE_VLP_RUN = 2'h2,
      FDSG_MODE_COMPUTE = 2'h3  // compute_operation_mode, inside very low power run
   } fdsg_mode_t;

   // mass erase sequencer
   typedef enum logic [1:0] {
      FDSG_ME_IDLE,
      FDSG_ME_RUN,
      FDSG_ME_BLOCKED
   } fdsg_me_state_t;

endpackage

// *** logic/fdsg_rate_tick.sv ***
// access rate strobe for the flash gate.
// assumes the system clock of the package; tick is a one-cycle pulse.
`timescale 1ns/1ns
module fdsg_rate_tick
   import fdsg_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic arst_n_i,
   // control
   input  wire logic run_i,   // count only while throttling applies
   output logic      tick_o   // one access slot
);

   // counter state
   typedef struct packed {
      logic [FDSG_DIV_W-1:0] cnt;
      logic                  tick;
   } fdsg_tick_st_t;

   fdsg_tick_st_t st_q;  // registered state
   fdsg_tick_st_t st_d;  // next state

   ////////////////////////////////////////////////////////////////////////////
   // next state: restart whenever throttling is off so the first slot comes a full FDSG_LP_DIV cycles after entry
   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (!run_i) begin
         st_d.cnt = '0;
      end else if (st_q.cnt == FDSG_DIV_W'(FDSG_LP_DIV - 1)) begin
         st_d.cnt  = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + FDSG_DIV_W'(1);
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick_o = st_q.tick;

endmodule // fdsg_rate_tick

// *** logic/fdsg_gate.sv ***
// flash debug security gate: holds the loaded security state, filters debug
// memory traffic, runs the debugger mass erase and applies power mode limits.
// assumes the flash controller answers every forwarded request with an ack
// pulse and a mass erase with a done pulse; avalon master as published.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns

// Operation
// R01 - load security byte at reset before debug
// R02 - unsecured only for encoding 10
// R03 - secured: debug gets mass erase only
// R04 - processor flash path ignores security
// R05 - unsecured: all commands for debug, processor
// R06 - secured: boundary scan kept, debug off
// R07 - debugger request bit starts mass erase
// R08 - disabled mass erase never starts
// R09 - host avoids program in fast, low modes
// R10 - low power: 1 MHz, no program, compute: no registers
// R11 - request bit clears on done, else sticks
// R12 - erase disable from enable and state fields
// R13 - blocked debug access changes nothing, no data
module fdsg_gate
   import fdsg_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   // configuration and power mode
   input  wire logic [7:0]  cfg_byte_i,      // security byte of the config field
   input  wire logic [1:0]  pwr_mode_i,      // fdsg_mode_t code
   // avalon slave, debug control access port
   input  wire logic [3:0]  av_address_i,
   input  wire logic        av_read_i,
   input  wire logic        av_write_i,
   input  wire logic [31:0] av_writedata_i,
   input  wire logic [3:0]  av_byteenable_i,
   output logic [31:0]      av_readdata_o,
   output logic             av_waitrequest_o,
   // debug memory access in
   input  wire logic        dbg_req_i,
   input  wire logic        dbg_we_i,
   input  wire logic [31:0] dbg_addr_i,
   input  wire logic [31:0] dbg_wdata_i,
   output logic             dbg_ack_o,
   output logic             dbg_err_o,
   output logic [31:0]      dbg_rdata_o,
   // debug memory access out to flash
   output logic             dfl_req_o,
   output logic             dfl_we_o,
   output logic [31:0]      dfl_addr_o,
   output logic [31:0]      dfl_wdata_o,
   input  wire logic        dfl_ack_i,
   input  wire logic [31:0] dfl_rdata_i,
   // processor flash path
   input  wire logic        cpu_req_i,
   input  wire logic        cpu_pe_i,        // program or erase command
   input  wire logic        cpu_reg_i,       // flash register access
   output logic             cpu_fl_req_o,
   output logic             cpu_err_o,
   // mass erase and debug controls
   output logic             erase_start_o,
   input  wire logic        erase_done_i,
   output logic             debug_en_o,
   output logic             bscan_en_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic           loaded;     // config byte captured
      logic [1:0]     state_f;    // security_state_field
      logic [1:0]     mef;        // mass_erase_enable_field
      logic           me_req;     // control bit 0
      logic           dbg_dis;    // control bit 1
      fdsg_me_state_t me;         // erase sequencer
      logic           start;      // erase start pulse
      logic           av_ack;     // avalon answer cycle
      logic [31:0]    av_rdata;
      logic           dbusy;      // debug access forwarded, waiting ack
      logic           dack;
      logic           derr;
      logic [31:0]    drdata;
   } fdsg_st_t;

   fdsg_st_t st_q;  // registered state
   fdsg_st_t st_d;  // next state

   logic tick;      // low power access slot

   // decode shared by gate and assertions
   function automatic logic is_secured(input logic [1:0] f);
      is_secured = (f != FDSG_STATE_UNSECURE);
   endfunction

   function automatic logic me_disabled(input logic [1:0] f, input logic [1:0] m);
      me_disabled = is_secured(f) && (m == FDSG_MEF_DISABLED);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // combinational views
   logic secured;    // not yet loaded counts as secured
   logic me_off;
   logic low_pwr;
   logic compute;
   logic slot_ok;
   logic av_req;
   logic ctl_wr;
   logic dbg_open;

   // R02 secured decode
   assign secured  = !st_q.loaded || is_secured(st_q.state_f);
   // R12 erase disable decode
   assign me_off   = me_disabled(st_q.state_f, st_q.mef);
   assign low_pwr  = (pwr_mode_i == FDSG_MODE_VLP_RUN) || (pwr_mode_i == FDSG_MODE_COMPUTE);
   assign compute  = (pwr_mode_i == FDSG_MODE_COMPUTE);
   // R10 rate cap slots
   assign slot_ok  = !low_pwr || tick;
   assign av_req   = (av_read_i || av_write_i) && !st_q.av_ack;
   // control writes land at the answer edge, where the master sees waitrequest low
   assign ctl_wr   = av_write_i && st_q.av_ack && (av_address_i == FDSG_CONTROL_OFS)
                     && av_byteenable_i[0];
   // R03 debug gets no memory while secured; R05 open when unsecured and debug disable clear
   assign dbg_open = !secured && !st_q.dbg_dis;

   fdsg_rate_tick u_tick (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .run_i     (low_pwr),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d       = st_q;
      st_d.start = 1'b0;
      st_d.dack  = 1'b0;
      st_d.derr  = 1'b0;
      // R01 capture security byte right after reset release
      if (!st_q.loaded) begin
         st_d.loaded  = 1'b1;
         st_d.state_f = cfg_byte_i[FDSG_CFG_STATE_LSB +: 2];
         st_d.mef     = cfg_byte_i[FDSG_CFG_MEF_LSB +: 2];
      end
      // avalon: answer one cycle after the request is seen
      st_d.av_ack = av_req;
      if (av_req && av_read_i) begin
         unique case (av_address_i)
            FDSG_STATUS_OFS: begin
               st_d.av_rdata = {24'h000000, (st_q.me == FDSG_ME_RUN), st_q.loaded,
                                me_off, secured, st_q.mef, st_q.state_f};
            end
            FDSG_CONTROL_OFS: begin
               st_d.av_rdata = {30'h00000000, st_q.dbg_dis, st_q.me_req};
            end
            default: begin
               st_d.av_rdata = 32'h00000000;
            end
         endcase
      end
      if (ctl_wr) begin
         st_d.dbg_dis = av_writedata_i[FDSG_CT_DBG_DIS];
      end
      // erase sequencer
      unique case (st_q.me)
         FDSG_ME_IDLE: begin
            if (st_q.me_req && st_q.loaded) begin
               // R08 disabled erase parks the request
               if (me_off) begin
                  st_d.me = FDSG_ME_BLOCKED;
               // R10 no erase launched in the low power modes
               end else if (!low_pwr) begin
                  // R07 launch erase of all blocks, protection ignored
                  st_d.me    = FDSG_ME_RUN;
                  st_d.start = 1'b1;
               end
            end
         end
         FDSG_ME_RUN: begin
            // R11 self clear on completion
            if (erase_done_i) begin
               st_d.me     = FDSG_ME_IDLE;
               st_d.me_req = 1'b0;
            end
         end
         FDSG_ME_BLOCKED: begin
            // R11 request stays up until system reset
            st_d.me = FDSG_ME_BLOCKED;
         end
         // unused code: fall back to idle
         default: begin
            st_d.me = FDSG_ME_IDLE;
         end
      endcase
      // R07 debugger sets the request; set wins over the done clear
      if (ctl_wr && av_writedata_i[FDSG_CT_ME_REQ]) begin
         st_d.me_req = 1'b1;
      end
      // debug memory path
      if (st_q.dbusy) begin
         if (dfl_ack_i) begin
            st_d.dbusy  = 1'b0;
            st_d.dack   = 1'b1;
            st_d.drdata = dfl_rdata_i;
         end
      end else if (dbg_req_i && !st_q.dack) begin
         if (!dbg_open) begin
            // R13 refuse with error, no flash activity, zero data
            st_d.dack   = 1'b1;
            st_d.derr   = 1'b1;
            st_d.drdata = 32'h00000000;
         end else if (slot_ok) begin
            st_d.dbusy = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q         <= '0;
         st_q.state_f <= FDSG_STATE_RST;
         st_q.mef     <= FDSG_MEF_RST;
         st_q.me      <= FDSG_ME_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign av_readdata_o    = st_q.av_rdata;
   assign av_waitrequest_o = (av_read_i || av_write_i) && !st_q.av_ack;
   assign dbg_ack_o        = st_q.dack;
   assign dbg_err_o        = st_q.derr;
   assign dbg_rdata_o      = st_q.drdata;
   // R03 flash request only while open and forwarded
   assign dfl_req_o        = st_q.dbusy;
   assign dfl_we_o         = dbg_we_i;
   assign dfl_addr_o       = dbg_addr_i;
   assign dfl_wdata_o      = dbg_wdata_i;
   // R04 processor path never looks at security
   // R10 program/erase refused in low power, registers refused in compute mode
   assign cpu_err_o        = cpu_req_i && ((low_pwr && cpu_pe_i) || (compute && cpu_reg_i));
   assign cpu_fl_req_o     = cpu_req_i && !cpu_err_o && slot_ok;
   assign erase_start_o    = st_q.start;
   // R06 boundary scan always on, debug logic off while secured
   assign debug_en_o       = dbg_open;
   assign bscan_en_o       = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_load_first: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R01
      !st_q.loaded |-> !dfl_req_o && !erase_start_o)
      else $error("debug flash traffic before security load");
   a_secure_decode: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R02
      st_q.loaded |-> (debug_en_o |-> st_q.state_f == 2'h2))
      else $error("debug open with secured encoding");
   a_secured_no_mem: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R03
      secured && !st_q.dbusy |=> !dfl_req_o)
      else $error("secured debug reached flash");
   a_cpu_passes: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R04
      cpu_req_i && !low_pwr && !compute |-> cpu_fl_req_o)
      else $error("processor access stalled in run mode");
   a_open_fwd: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R05
      dbg_open && !low_pwr && dbg_req_i && !st_q.dbusy && !st_q.dack |=> dfl_req_o)
      else $error("unsecured debug access not forwarded");
   a_bscan_kept: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R06
      bscan_en_o && (!secured || !debug_en_o))
      else $error("boundary scan or debug enable wrong");
   a_erase_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R07
      st_q.me == FDSG_ME_IDLE && st_q.me_req && st_q.loaded && !me_off && !low_pwr
      |=> erase_start_o ##1 st_q.me == FDSG_ME_RUN)
      else $error("mass erase request not launched");
   a_erase_blocked: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R08
      st_q.me == FDSG_ME_BLOCKED |-> !erase_start_o)
      else $error("blocked mass erase started");
   a_lp_no_erase: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R10
      $rose(erase_start_o) |-> !$past(low_pwr))
      else $error("erase launched in low power mode");
   a_req_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R11
      st_q.me == FDSG_ME_RUN && erase_done_i && !ctl_wr |=> !st_q.me_req)
      else $error("request bit not cleared on done");
   a_req_sticks: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R11
      st_q.me == FDSG_ME_BLOCKED |=> st_q.me_req [*2])
      else $error("blocked request bit dropped");
   a_me_decode: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R12
      st_q.loaded && st_q.me_req && st_q.me == FDSG_ME_IDLE && me_off
      |=> st_q.me == FDSG_ME_BLOCKED)
      else $error("disabled erase not parked");
   a_blocked_err: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R13
      dbg_req_i && !dbg_open && !st_q.dbusy && !st_q.dack
      |=> dbg_ack_o && dbg_err_o && dbg_rdata_o == 32'h00000000 && !dfl_req_o)
      else $error("blocked debug access misanswered");

   c_erase_done: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      erase_start_o ##[1:20] erase_done_i);
   c_erase_park: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      st_q.me == FDSG_ME_BLOCKED);
   c_dbg_read: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      dfl_req_o && dfl_ack_i ##1 dbg_ack_o);
   c_dbg_refused: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      dbg_ack_o && dbg_err_o);

endmodule // fdsg_gate

// *** dv/fdsg_flash_model.sv ***
// flash controller stand-in on the far side of the security gate.
// assumes one clock; the gate holds dfl_req_i until it sees one ack pulse.
`timescale 1ns/1ns
module fdsg_flash_model (
   // clock, reset and pacing
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        slow_i,       // answer after 5 waits, else 1
   // forwarded debug requests
   input  wire logic        dfl_req_i,
   input  wire logic        dfl_we_i,
   input  wire logic [31:0] dfl_addr_i,
   input  wire logic [31:0] dfl_wdata_i,
   output logic             dfl_ack_o,
   output logic [31:0]      dfl_rdata_o,
   // mass erase
   input  wire logic        erase_start_i,
   output logic             erase_done_o
);
   logic [31:0] mem [16];   // small store, address wraps
   logic [2:0]  wait_q;     // waits spent on current request
   logic [3:0]  ecnt_q;     // erase cycles left
   initial for (int i = 0; i < 16; i++) mem[i] = 32'hA5A50000 + i;
   ////////////////////////////////////////
   // one ack per request; data toggles when idle so stale data never matches
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dfl_ack_o <= 1'b0;
         dfl_rdata_o <= 32'h0;
         wait_q <= 3'h0;
         erase_done_o <= 1'b0;
         ecnt_q <= 4'h0;
      end else begin
         dfl_ack_o <= 1'b0;
         erase_done_o <= 1'b0;
         dfl_rdata_o <= ~dfl_rdata_o;
         if (dfl_req_i && !dfl_ack_o) begin
            if (wait_q >= (slow_i ? 3'h5 : 3'h1)) begin
               dfl_ack_o <= 1'b1;
               wait_q <= 3'h0;
               dfl_rdata_o <= mem[dfl_addr_i[5:2]];
               if (dfl_we_i) mem[dfl_addr_i[5:2]] <= dfl_wdata_i;
            end else wait_q <= wait_q + 3'h1;
         end
         if (erase_start_i) ecnt_q <= 4'h8;
         else if (ecnt_q != 4'h0) ecnt_q <= ecnt_q - 4'h1;
         if (ecnt_q == 4'h1) begin
            erase_done_o <= 1'b1;
            for (int i = 0; i < 16; i++) mem[i] <= 32'hFFFFFFFF;
         end
      end
   end
endmodule // fdsg_flash_model

// *** dv/tb_fdsg_gate.sv ***
// bench for the flash debug security gate: avalon master, debug requester,
// processor path driver; the flash side is the model in its own file.
`timescale 1ns/1ns
module tb_fdsg_gate;
   import fdsg_pkg::*;
   logic        ref_clk_i = 1'b0, arst_n_i = 1'b0, slow = 1'b0;
   logic [7:0]  cfg_byte_i = 8'h00;
   logic [1:0]  pwr_mode_i = 2'h0;
   logic [3:0]  av_address_i = 4'h0, av_byteenable_i = 4'hF;
   logic        av_read_i = 1'b0, av_write_i = 1'b0, dbg_req_i = 1'b0, dbg_we_i = 1'b0;
   logic [31:0] av_writedata_i = 32'h0, dbg_addr_i = 32'h0, dbg_wdata_i = 32'h0;
   logic        cpu_req_i = 1'b0, cpu_pe_i = 1'b0, cpu_reg_i = 1'b0;
   logic [31:0] av_readdata_o, dbg_rdata_o, dfl_addr_o, dfl_wdata_o, dfl_rdata_i;
   logic        av_waitrequest_o, dbg_ack_o, dbg_err_o, dfl_req_o, dfl_we_o, dfl_ack_i;
   logic        cpu_fl_req_o, cpu_err_o, erase_start_o, erase_done_i, debug_en_o, bscan_en_o;
   int          n_fail = 0, comparisons = 0, cyc = 0, n_dfl = 0, n_ers = 0;

   fdsg_gate u_dut (.ref_clk_i, .arst_n_i, .cfg_byte_i, .pwr_mode_i, .av_address_i,
      .av_read_i, .av_write_i, .av_writedata_i, .av_byteenable_i, .av_readdata_o,
      .av_waitrequest_o, .dbg_req_i, .dbg_we_i, .dbg_addr_i, .dbg_wdata_i, .dbg_ack_o,
      .dbg_err_o, .dbg_rdata_o, .dfl_req_o, .dfl_we_o, .dfl_addr_o, .dfl_wdata_o,
      .dfl_ack_i, .dfl_rdata_i, .cpu_req_i, .cpu_pe_i, .cpu_reg_i, .cpu_fl_req_o,
      .cpu_err_o, .erase_start_o, .erase_done_i, .debug_en_o, .bscan_en_o);
   fdsg_flash_model u_flash (.ref_clk_i, .arst_n_i, .slow_i(slow), .dfl_req_i(dfl_req_o),
      .dfl_we_i(dfl_we_o), .dfl_addr_i(dfl_addr_o), .dfl_wdata_i(dfl_wdata_o),
      .dfl_ack_o(dfl_ack_i), .dfl_rdata_o(dfl_rdata_i), .erase_start_i(erase_start_o),
      .erase_done_o(erase_done_i));
   ////////////////////////////////////////
   // clock, traffic counters and hang limit
   always #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (dfl_req_o === 1'b1) n_dfl <= n_dfl + 1;
      if (erase_start_o === 1'b1) n_ers <= n_ers + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   ////////////////////////////////////////
   task automatic conclude();
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // reset held four cycles with the given security byte
   task automatic rst(input logic [7:0] c);
      arst_n_i <= 1'b0;
      cfg_byte_i <= c;
      repeat (4) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
   endtask
   // avalon cycle: held until the edge that sees waitrequest low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      logic w;
      av_address_i <= a;
      av_writedata_i <= wd;
      av_write_i <= wr;
      av_read_i <= !wr;
      // waitrequest and read data are taken at the rising edge, before it updates them
      do begin
         @(posedge ref_clk_i);
         w = av_waitrequest_o;
         rd = av_readdata_o;
      end while (w !== 1'b0);
      av_read_i <= 1'b0;
      av_write_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // debug memory access held until its ack pulse
   task automatic dbg(input logic we, input logic [31:0] a, input logic [31:0] wd,
                      output logic e, output logic [31:0] rd);
      logic k;
      dbg_we_i <= we;
      dbg_addr_i <= a;
      dbg_wdata_i <= wd;
      dbg_req_i <= 1'b1;
      do begin
         @(negedge ref_clk_i);
         k = dbg_ack_o;
         e = dbg_err_o;
         rd = dbg_rdata_o;
         @(posedge ref_clk_i);
      end while (k !== 1'b1);
      dbg_req_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   function automatic logic [31:0] st_exp(input logic [7:0] c);
      logic s;
      s = (c[1:0] !== FDSG_STATE_UNSECURE);
      return {24'h0, 1'b0, 1'b1, s && (c[5:4] === FDSG_MEF_DISABLED), s, c[5:4], c[1:0]};
   endfunction
   ////////////////////////////////////////
   // every security encoding: status, debug path, processor path
   task automatic t_codes();
      logic [31:0] rd;
      logic e;
      int d;
      for (int s = 0; s < 4; s++) begin
         rst({4'h3, 2'h0, s[1:0]});
         av(1'b0, FDSG_STATUS_OFS, 32'h0, rd);
         chk("status", st_exp(cfg_byte_i), rd);
         d = n_dfl;
         dbg(1'b0, 32'h4, 32'h0, e, rd);
         chk("dbg err", s != 2, e);
         chk("dbg rdata", (s == 2) ? 32'hA5A50001 : 32'h0, rd);
         chk("dfl used", s == 2, n_dfl != d);
         chk("debug_en", s == 2, debug_en_o);
         chk("bscan_en", 1'b1, bscan_en_o);
         cpu_req_i <= 1'b1;
         @(negedge ref_clk_i);
         chk("cpu req", 1'b1, cpu_fl_req_o);
         @(posedge ref_clk_i) cpu_req_i <= 1'b0;
      end
   endtask
   // open device, slow flash: write then read back, run mode only
   task automatic t_open_rw();
      logic [31:0] rd;
      logic e;
      rst(8'h32);
      slow <= 1'b1;
      dbg(1'b1, 32'hC, 32'h1234ABCD, e, rd);
      dbg(1'b0, 32'hC, 32'h0, e, rd);
      chk("rw err", 1'b0, e);
      chk("rw data", 32'h1234ABCD, rd);
      slow <= 1'b0;
   endtask
   // low power limits on the processor path and on the debugger mass erase
   task automatic t_lp();
      int n;
      logic [31:0] rd;
      rst(8'h32);
      pwr_mode_i <= FDSG_MODE_VLP_RUN;
      cpu_req_i <= 1'b1;
      cpu_pe_i <= 1'b1;
      @(negedge ref_clk_i);
      chk("lp pe err", 1'b1, cpu_err_o);
      chk("lp pe req", 1'b0, cpu_fl_req_o);
      @(posedge ref_clk_i) cpu_pe_i <= 1'b0;
      n = 0;
      repeat (100) begin
         @(negedge ref_clk_i);
         n += (cpu_fl_req_o === 1'b1);
      end
      chk("lp slots", 100 / FDSG_LP_DIV, n);
      @(posedge ref_clk_i) pwr_mode_i <= FDSG_MODE_COMPUTE;
      cpu_reg_i <= 1'b1;
      @(negedge ref_clk_i);
      chk("cpo reg err", 1'b1, cpu_err_o);
      // a debugger erase asked for in low power waits for run mode
      n = n_ers;
      @(posedge ref_clk_i);
      av(1'b1, FDSG_CONTROL_OFS, 32'h1, rd);
      repeat (20) @(posedge ref_clk_i);
      chk("lp erase held", n, n_ers);
      pwr_mode_i <= FDSG_MODE_RUN;
      cpu_pe_i <= 1'b1;
      @(negedge ref_clk_i);
      chk("run err", 1'b0, cpu_err_o);
      repeat (20) @(posedge ref_clk_i);
      chk("erase after lp", n + 1, n_ers);
      @(posedge ref_clk_i) cpu_req_i <= 1'b0;
      cpu_pe_i <= 1'b0;
      cpu_reg_i <= 1'b0;
   endtask
   // debug disable bit, unmapped place, read-only status
   task automatic t_dis();
      logic [31:0] rd;
      logic e;
      rst(8'h32);
      av(1'b1, FDSG_CONTROL_OFS, 32'h2, rd);
      chk("dbg off", 1'b0, debug_en_o);
      dbg(1'b0, 32'h0, 32'h0, e, rd);
      chk("dbg off err", 1'b1, e);
      av(1'b0, FDSG_CONTROL_OFS, 32'h0, rd);
      chk("ctl rw", 32'h2, rd);
      av(1'b1, 4'h8, 32'hFF, rd);
      av(1'b0, 4'h8, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      av(1'b1, FDSG_STATUS_OFS, 32'hFF, rd);
      av(1'b0, FDSG_STATUS_OFS, 32'h0, rd);
      chk("status ro", st_exp(8'h32), rd);
   endtask
   // debugger mass erase, allowed or blocked
   task automatic t_erase(input logic [7:0] c, input logic run);
      logic [31:0] rd;
      int n0;
      rst(c);
      av(1'b0, FDSG_CONTROL_OFS, 32'h0, rd);
      chk("ctl after rst", 32'h0, rd);
      n0 = n_ers;
      av(1'b1, FDSG_CONTROL_OFS, 32'h1, rd);
      repeat (30) @(posedge ref_clk_i);
      chk("erase start", run, n_ers - n0);
      av(1'b0, FDSG_CONTROL_OFS, 32'h0, rd);
      chk("erase bit", !run, rd[0]);
      av(1'b0, FDSG_STATUS_OFS, 32'h0, rd);
      chk("erase off", !run, rd[5]);
   endtask
   ////////////////////////////////////////
   initial begin
      logic [31:0] rd;
      logic e;
      t_codes();
      t_open_rw();
      t_lp();
      t_dis();
      t_erase(8'h33, 1'b1);
      t_erase(8'h23, 1'b0);
      t_erase(8'h22, 1'b1);
      dbg(1'b0, 32'h0, 32'h0, e, rd);
      chk("erased", 32'hFFFFFFFF, rd);
      conclude();
   end
endmodule // tb_fdsg_gate
